// [pkg/wdn_defines.svh]
/*
 * Constants of the watchdog and non-maskable interrupt block.
 * Assumes inclusion by bare name from the package and the top module.
 */
// Notes on behaviour
// - Counter advances on divided 256 Hz tick.
// - Reset leaves the run enable set.
// - Ten-bit counter overflow raises the interrupt.
// - Counts in halt; overflow wakes the core.
// - Interrupt-disable flag does not block it.
// - Refused until both stack halves loaded.
// - Handler vector is 0100H.
// - Bit D1 run enable, readable.
// - Writing one to D0 clears counter.
// - Clear strobe always reads as zero.
// - Bits D3 and D2 read zero.
`ifndef WDN_DEFINES_SVH
`define WDN_DEFINES_SVH

// ==========================================================
// Timing
`define WDN_CLK_HZ      125000000
`define WDN_SRC_HZ      256
`define WDN_TICK_DIV    (`WDN_CLK_HZ / `WDN_SRC_HZ)
`define WDN_CNT_W       10
`define WDN_CNT_MAX     10'h3FF

// ==========================================================
// Register map: indices, byte address is four times the index
`define WDN_CTRL_IDX    16'hFF07
`define WDN_STAT_IDX    16'hFF08
`define WDN_ADDR_W      18
`define WDN_CLR_BIT     0
`define WDN_EN_BIT      1
`define WDN_EN_RST      1'b1
`define WDN_ST_PEND_BIT 10
`define WDN_ST_MASK_BIT 11
`define WDN_NMI_VECTOR  16'h0100

`endif

// [pkg/wdn_pkg.sv]
/*
 * Types of the watchdog block.
 * Assumes the constants header is on the include path.
 */
`include "wdn_defines.svh"

package wdn_pkg;

    // ======================================================
    // Bus carrier
    typedef struct packed {
        logic                   read;
        logic                   write;
        logic [`WDN_ADDR_W-1:0] address;
        logic [31:0]            writedata;
        logic [3:0]             byteenable;
    } wdn_avs_req_t;

    // ======================================================
    // Bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } wdn_bus_st_t;

endpackage

// [src/wdn_top.sv]
/*
 * Watchdog counter with non-maskable interrupt request toward the core.
 * Assumes an Avalon-MM master and a core that acknowledges the request.
 */
`timescale 1ns/1ps
`include "wdn_defines.svh"

module wdn_top #(
    parameter int unsigned TICK_DIV = `WDN_TICK_DIV
) (
    input  wire logic                 MCLK_I,
    input  wire logic                 RST_I,
    input  wire wdn_pkg::wdn_avs_req_t AVS_REQ_I,
    output logic [31:0]               AVS_READDATA_O,
    output logic                      AVS_WAITREQUEST_O,
    input  wire logic                 CORE_HALT_I,
    input  wire logic                 IRQ_DISABLE_I,
    input  wire logic                 SP_HALF_ONE_WR_I,
    input  wire logic                 SP_HALF_TWO_WR_I,
    input  wire logic                 NMI_ACK_I,
    output logic                      NMI_REQ_O,
    output logic [15:0]               NMI_VECTOR_O,
    output logic                      HALT_WAKE_O
);
    import wdn_pkg::*;

    localparam int unsigned DIV_W = $clog2(TICK_DIV);

    // ======================================================
    // Elaboration check
    generate
        if (TICK_DIV < 2)
        begin : g_bad_div
            $error("TICK_DIV must be at least two.");
        end
    endgenerate

    // ======================================================
    // Declarations
    logic [DIV_W-1:0]       div_reg;
    logic [DIV_W-1:0]       div_next;
    logic                   tick_reg;
    logic                   tick_next;
    logic [`WDN_CNT_W-1:0]  cnt_reg;
    logic [`WDN_CNT_W-1:0]  cnt_next;
    logic                   en_reg;
    logic                   en_next;
    logic                   pend_reg;
    logic                   pend_next;
    logic                   mask_reg;
    logic                   mask_next;
    logic                   half_one_reg;
    logic                   half_one_next;
    logic                   half_two_reg;
    logic                   half_two_next;
    logic                   nmi_reg;
    logic                   nmi_next;
    logic                   wake_reg;
    logic                   wake_next;
    logic [15:0]            vec_reg;
    logic [15:0]            vec_next;
    wdn_bus_st_t            bus_reg;
    wdn_bus_st_t            bus_next;
    logic [31:0]            rd_reg;
    logic [31:0]            rd_next;
    logic                   wait_reg;
    logic                   wait_next;
    logic                   req;
    logic                   commit_wr;
    logic                   hit_ctrl;
    logic                   hit_stat;
    logic                   clr_wr;
    logic                   en_wr;
    logic                   ovf;

    // ======================================================
    // Address decode
    always_comb
    begin
        req      = AVS_REQ_I.read | AVS_REQ_I.write;
        hit_ctrl = 1'b0;
        hit_stat = 1'b0;
        if (AVS_REQ_I.address == {`WDN_CTRL_IDX, 2'b00})
        begin
            hit_ctrl = 1'b1;
        end
        else if (AVS_REQ_I.address == {`WDN_STAT_IDX, 2'b00})
        begin
            hit_stat = 1'b1;
        end
        commit_wr = AVS_REQ_I.write & (bus_reg == BUS_DONE);
        en_wr     = commit_wr & hit_ctrl & AVS_REQ_I.byteenable[0];
        clr_wr    = en_wr & AVS_REQ_I.writedata[`WDN_CLR_BIT];
    end

    // ======================================================
    // Bus slave
    // The write commits at the edge where waitrequest is seen low.
    always_comb
    begin
        bus_next  = bus_reg;
        wait_next = 1'b1;
        rd_next   = rd_reg;
        case (bus_reg)
            BUS_IDLE:
            begin
                if (req)
                begin
                    bus_next  = BUS_DONE;
                    wait_next = 1'b0;
                    rd_next   = 32'h0000_0000;
                    if (AVS_REQ_I.read & hit_ctrl)
                    begin
                        rd_next[`WDN_EN_BIT] = en_reg;
                    end
                    else if (AVS_REQ_I.read & hit_stat)
                    begin
                        rd_next[`WDN_CNT_W-1:0]     = cnt_reg;
                        rd_next[`WDN_ST_PEND_BIT]   = pend_reg;
                        rd_next[`WDN_ST_MASK_BIT]   = mask_reg;
                    end
                end
            end
            BUS_DONE:
            begin
                bus_next  = BUS_IDLE;
            end
            default:
            begin
                bus_next  = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            bus_reg  <= BUS_IDLE;
            wait_reg <= 1'b1;
            rd_reg   <= 32'h0000_0000;
        end
        else
        begin
            bus_reg  <= bus_next;
            wait_reg <= wait_next;
            rd_reg   <= rd_next;
        end
    end

    // ======================================================
    // Watchdog counter
    // The prescaler is not cleared by the strobe, so the timeout
    // lands between 1023 and 1024 ticks after a clear, just under four seconds.
    always_comb
    begin
        div_next  = div_reg + DIV_W'(1);
        tick_next = 1'b0;
        if (div_reg == DIV_W'(TICK_DIV - 1))
        begin
            div_next  = '0;
            tick_next = 1'b1;
        end
        en_next = en_wr ? AVS_REQ_I.writedata[`WDN_EN_BIT] : en_reg;
        ovf      = en_reg & tick_reg & (cnt_reg == `WDN_CNT_MAX);
        cnt_next = cnt_reg;
        if (clr_wr)
        begin
            cnt_next = '0;
        end
        else if (en_reg & tick_reg)
        begin
            cnt_next = cnt_reg + `WDN_CNT_W'(1);
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            div_reg  <= '0;
            tick_reg <= 1'b0;
            cnt_reg  <= '0;
            en_reg   <= `WDN_EN_RST;
        end
        else
        begin
            div_reg  <= div_next;
            tick_reg <= tick_next;
            cnt_reg  <= cnt_next;
            en_reg   <= en_next;
        end
    end

    // ======================================================
    // Interrupt request toward the core
    always_comb
    begin
        pend_next = ovf | (pend_reg & ~NMI_ACK_I);
        half_one_next = half_one_reg | SP_HALF_ONE_WR_I;
        half_two_next = half_two_reg | SP_HALF_TWO_WR_I;
        mask_next     = mask_reg;
        if (SP_HALF_ONE_WR_I | SP_HALF_TWO_WR_I)
        begin
            mask_next = 1'b1;
        end
        if (half_one_next & half_two_next)
        begin
            mask_next     = 1'b0;
            half_one_next = 1'b0;
            half_two_next = 1'b0;
        end
        nmi_next  = pend_next & ~mask_next;
        wake_next = nmi_next & CORE_HALT_I;
        vec_next  = `WDN_NMI_VECTOR;
    end

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            pend_reg <= 1'b0;
            mask_reg <= 1'b1;
            half_one_reg <= 1'b0;
            half_two_reg <= 1'b0;
            nmi_reg  <= 1'b0;
            wake_reg <= 1'b0;
            vec_reg  <= 16'h0000;
        end
        else
        begin
            pend_reg <= pend_next;
            mask_reg <= mask_next;
            half_one_reg <= half_one_next;
            half_two_reg <= half_two_next;
            nmi_reg  <= nmi_next;
            wake_reg <= wake_next;
            vec_reg  <= vec_next;
        end
    end

    assign AVS_READDATA_O    = rd_reg;
    assign AVS_WAITREQUEST_O = wait_reg;
    assign NMI_REQ_O         = nmi_reg;
    assign NMI_VECTOR_O      = vec_reg;
    assign HALT_WAKE_O       = wake_reg;

    // ======================================================
    // Assertions
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);

    AST_TICK_PERIOD: assert property (
        tick_reg |=> !tick_reg [*1])
        else $error("Tick lasted more than one cycle.");
    AST_CNT_ADV: assert property (
        (en_reg && tick_reg && !clr_wr)
        |=> cnt_reg == $past(cnt_reg) + 10'h001)
        else $error("Counter did not advance on tick.");
    AST_OVF_PEND: assert property (
        (en_reg && tick_reg && cnt_reg == 10'h3FF) |=> pend_reg)
        else $error("Overflow did not set pending.");
    AST_WAKE: assert property (
        (pend_reg && !mask_reg && CORE_HALT_I && !NMI_ACK_I &&
         !SP_HALF_ONE_WR_I && !SP_HALF_TWO_WR_I) |=> HALT_WAKE_O)
        else $error("Halt not released by request.");
    AST_NMI_MASK: assert property (
        mask_reg |-> !NMI_REQ_O)
        else $error("Request shown while masked.");
    AST_VECTOR: assert property (
        !$past(RST_I) |-> NMI_VECTOR_O == 16'h0100)
        else $error("Wrong handler vector.");
    AST_EN_WR: assert property (
        en_wr |=> en_reg == $past(AVS_REQ_I.writedata[1]))
        else $error("Enable write not stored.");
    AST_CLR: assert property (
        clr_wr |=> cnt_reg == 10'h000)
        else $error("Clear strobe did not clear counter.");
    AST_RD_ZERO: assert property (
        (AVS_REQ_I.read && hit_ctrl && bus_reg == BUS_IDLE)
        |=> AVS_READDATA_O[3:2] == 2'b00 && !AVS_READDATA_O[0])
        else $error("Unstored control bits read nonzero.");
    AST_HOLD: assert property (
        (pend_reg && !NMI_ACK_I) |=> pend_reg)
        else $error("Pending dropped without acknowledge.");
    AST_DIS: assert property (
        (!en_reg && !clr_wr) |=> $stable(cnt_reg) && !$rose(pend_reg))
        else $error("Disabled timer moved.");

    CV_OVF:   cover property (ovf);
    CV_CLR:   cover property (clr_wr);
    CV_WAKE:  cover property (HALT_WAKE_O);
    CV_UNMSK: cover property ($fell(mask_reg));

endmodule

// [tb/wdn_core_model.sv]
/*
 * Behavioural core facing the watchdog: loads both stack halves on
 * command and takes the request after a set delay.
 * Assumes the bench clock and reset.
 */
`timescale 1ns/1ps

module wdn_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        sp_load_i,
    input  wire logic [7:0]  ack_dly_i,
    input  wire logic        nmi_req_i,
    input  wire logic [15:0] vector_i,
    output logic             sp_one_o,
    output logic             sp_two_o,
    output logic             ack_o,
    output logic [15:0]      fetch_o
);
    logic [7:0] wait_cnt;
    logic       taken;

    // ==========================================================
    // Stack load and request intake
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sp_one_o <= 1'b0;
            sp_two_o <= 1'b0;
            ack_o    <= 1'b0;
            fetch_o  <= 16'h0000;
            wait_cnt <= 8'h00;
            taken    <= 1'b0;
        end
        else
        begin
            sp_one_o <= sp_load_i;
            sp_two_o <= sp_one_o;
            ack_o    <= 1'b0;
            if (!nmi_req_i)
            begin
                taken    <= 1'b0;
                wait_cnt <= 8'h00;
            end
            else if (!taken && wait_cnt == ack_dly_i)
            begin
                ack_o   <= 1'b1;
                taken   <= 1'b1;
                fetch_o <= vector_i;
            end
            else if (!taken)
                wait_cnt <= wait_cnt + 8'h01;
        end
    end
endmodule

// [tb/wdn_top_tb_top.sv]
/*
 * Self-checking bench of the watchdog block.
 * Assumes the package, the header and the core model are compiled.
 */
`timescale 1ns/1ps
`include "wdn_defines.svh"
`define CHK(nm, ex, got) \
    begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
    $display("wrong value %s exp %0h seen %0h", nm, ex, got); end end

module wdn_top_tb_top;
    import wdn_pkg::*;
    // A short prescaler keeps a full timeout near four thousand cycles.
    localparam int          TD   = 4;
    localparam logic [17:0] CTRL = 18'h3FC1C;
    localparam logic [17:0] STAT = 18'h3FC20;
    logic         clk     = 1'b0;
    logic         rst     = 1'b1;
    wdn_avs_req_t req     = '0;
    logic         halt    = 1'b0;
    logic         idis    = 1'b0;
    logic         sp_load = 1'b0;
    logic [7:0]   ack_dly = 8'h00;
    logic [31:0]  rdata;
    logic         wreq;
    logic         sp_one;
    logic         sp_two;
    logic         ack;
    logic         nmi;
    logic [15:0]  vec;
    logic         wake;
    logic [15:0]  fetch;
    logic [31:0]  d;
    int           e;
    int           miscompares = 0;
    int           comparisons = 0;

    wdn_top #(.TICK_DIV(TD)) dut (.MCLK_I(clk), .RST_I(rst),
        .AVS_REQ_I(req), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wreq), .CORE_HALT_I(halt),
        .IRQ_DISABLE_I(idis), .SP_HALF_ONE_WR_I(sp_one),
        .SP_HALF_TWO_WR_I(sp_two), .NMI_ACK_I(ack), .NMI_REQ_O(nmi),
        .NMI_VECTOR_O(vec), .HALT_WAKE_O(wake));
    wdn_core_model core (.clk_i(clk), .rst_i(rst), .sp_load_i(sp_load),
        .ack_dly_i(ack_dly), .nmi_req_i(nmi), .vector_i(vec),
        .sp_one_o(sp_one), .sp_two_o(sp_two), .ack_o(ack), .fetch_o(fetch));

    always #4 clk = ~clk;

    // ==========================================================
    // Shared tasks
    task automatic test_done();
        $display("miscompares %0d comparisons %0d", miscompares,
                 comparisons);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic hang();
        miscompares++;
        $display("wrong value wait exp done seen timeout");
        test_done();
    endtask

    task automatic bus(input logic w, input logic [17:0] a,
                       input logic [31:0] wd, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        req.read       <= ~w;
        req.write      <= w;
        req.address    <= a;
        req.writedata  <= wd;
        req.byteenable <= be;
        do
        begin
            @(posedge clk);
            n++;
            if (n > 20)
                hang();
        end
        while (wreq !== 1'b0);
        d = rdata;
        req.read  <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic wait_lvl(input logic lvl, input int lim);
        e = 0;
        while (nmi !== lvl)
        begin
            @(posedge clk);
            e++;
            if (e > lim)
                hang();
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        bus(0, CTRL, 0, 4'hF);
        `CHK("ctrl_rst", 32'h2, d)
        bus(0, STAT, 0, 4'hF);
        `CHK("cnt_rst", 1'b1, d[9:0] <= 10'h001)
        `CHK("pend_rst", 1'b0, d[10])
        `CHK("mask_rst", 1'b1, d[11])
        bus(1, 18'h00010, 32'hF, 4'hF);
        bus(0, 18'h00010, 0, 4'hF);
        `CHK("unmapped", 32'h0, d)
        bus(1, CTRL, 32'h0, 4'h0);
        bus(0, CTRL, 0, 4'hF);
        `CHK("be_low", 32'h2, d)
        bus(1, CTRL, 32'h0, 4'hF);
        bus(0, CTRL, 0, 4'hF);
        `CHK("en_off", 32'h0, d)
        bus(1, CTRL, 32'hF, 4'hF);
        bus(0, CTRL, 0, 4'hF);
        `CHK("ctrl_rd", 32'h2, d)
        bus(0, STAT, 0, 4'hF);
        `CHK("cnt_clr", 1'b1, d[9:0] <= 10'h001)
    endtask

    task automatic t_disable();
        // Disabling before the first timeout is what software must do.
        bus(1, CTRL, 32'h1, 4'hF);
        repeat (1100 * TD) @(posedge clk);
        bus(0, STAT, 0, 4'hF);
        `CHK("off_cnt", 10'h000, d[9:0])
        `CHK("off_pend", 1'b0, d[10])
        bus(1, CTRL, 32'h2, 4'hF);
        repeat (20 * TD) @(posedge clk);
        bus(1, CTRL, 32'h2, 4'hF);
        bus(0, STAT, 0, 4'hF);
        `CHK("clr_zero", 1'b1, d[9:0] >= 10'd18)
    endtask

    task automatic t_masked();
        bus(1, CTRL, 32'h3, 4'hF);
        e = 0;
        do
        begin
            bus(0, STAT, 0, 4'hF);
            e += 3;
            if (e > 1100 * TD)
                hang();
        end
        while (d[10] !== 1'b1);
        `CHK("masked", 1'b0, nmi)
        `CHK("mask_st", 1'b1, d[11])
        `CHK("ovf_win", 1'b1, e >= 1023*TD && e <= 1024*TD + 8)
        @(posedge clk);
        idis    <= 1'b1;
        halt    <= 1'b1;
        ack_dly <= 8'd10;
        sp_load <= 1'b1;
        @(posedge clk);
        sp_load <= 1'b0;
        wait_lvl(1'b1, 8);
        `CHK("wake", 1'b1, wake)
        wait_lvl(1'b0, 20);
        `CHK("hold", 1'b1, e >= 10 && e <= 14)
        `CHK("vector", `WDN_NMI_VECTOR, fetch)
        halt    <= 1'b0;
        ack_dly <= 8'd0;
    endtask

    task automatic t_timeout();
        // Periodic clears well inside the timeout keep the request away.
        repeat (3)
        begin
            bus(1, CTRL, 32'h3, 4'hF);
            repeat (900 * TD) @(posedge clk);
            `CHK("kick", 1'b0, nmi)
        end
        bus(1, CTRL, 32'h3, 4'hF);
        wait_lvl(1'b1, 1030 * TD);
        `CHK("tmo_win", 1'b1, e >= 1023*TD && e <= 1024*TD + 4)
        `CHK("no_wake", 1'b0, wake)
        wait_lvl(1'b0, 8);
        `CHK("ack_fast", 1'b1, e >= 1 && e <= 4)
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_disable();
        t_masked();
        t_timeout();
        test_done();
    end
endmodule
